// ===== hw/dhq_map.vh
// Object indices, sub-indices, field positions, reset values and timing counts
// for the diagnosis history queue. Definitions only.
`ifndef DHQ_MAP_VH
`define DHQ_MAP_VH

`define DHQ_IDX_DIAG 16'h2001
`define DHQ_IDX_HIST 16'h10F3
`define DHQ_IDX_PORT 16'hA000
`define DHQ_SI_CAP 8'h01
`define DHQ_SI_NEWEST 8'h02
`define DHQ_SI_ACK 8'h03
`define DHQ_SI_NEWAV 8'h04
`define DHQ_SI_FLAGS 8'h05
`define DHQ_SI_FIRST 8'h06
`define DHQ_SI_LAST 8'h45
`define DHQ_SI_LOW 8'h05
`define DHQ_DEPTH 64
`define DHQ_CAP_RST 8'h40
`define DHQ_FLG_EMCY 0
`define DHQ_FLG_NOINFO 1
`define DHQ_FLG_NOWARN 2
`define DHQ_FLG_NOERR 3
`define DHQ_FLG_ACKMODE 4
`define DHQ_FLG_OVR 5
`define DHQ_FLG_WMASK 16'h001F
`define DHQ_FLG_RST 16'h0000
`define DHQ_SEV_INFO 2'h0
`define DHQ_SEV_WARN 2'h1
`define DHQ_SEV_ERR 2'h2
`define DHQ_ABORT_NOMSG 32'h0609_0030
`define DHQ_ABORT_HIGH 32'h0609_0031
`define DHQ_ABORT_LOW 32'h0609_0032
`define DHQ_ABORT_NOOBJ 32'h0602_0000
`define DHQ_LS_INACTIVE 8'h00
`define DHQ_LS_DI 8'h01
`define DHQ_LS_DO 8'h02
`define DHQ_LS_ESTAB 8'h03
`define DHQ_LS_OPERATE 8'h08
`define DHQ_LS_STOP 8'h09
`define DHQ_CLK_KHZ 40000
`define DHQ_MS_CYCLES 16'h9C40
`define DHQ_BLANK_MS_MAX 8'hFF
`define DHQ_BLANK_MS_RST 8'h50
`define DHQ_FILT_MS 5
// Filter length in clocks: 5 ms at 40 MHz
`define DHQ_FILT_CYCLES 18'h3_0D40
`define DHQ_NCH 8

`endif

// ===== hw/dhq_top.v
// Diagnosis history queue with output fault blanking and per-port link status.
// Assumes a mailbox engine presenting object accesses as one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "dhq_map.vh"

module dhq_top (
  input wire SYS_CLK_IN,
  input wire RST_IN,
  input wire OBJ_WR_IN,
  input wire OBJ_RD_IN,
  input wire [15:0] OBJ_INDEX_IN,
  input wire [7:0] OBJ_SUB_IN,
  input wire [31:0] OBJ_WDATA_IN,
  output reg [31:0] OBJ_RDATA_OUT,
  output reg OBJ_DONE_OUT,
  output reg OBJ_ABORT_OUT,
  output reg [31:0] OBJ_ABORT_CODE_OUT,
  input wire MSG_VALID_IN,
  input wire [1:0] MSG_SEV_IN,
  input wire [31:0] MSG_DATA_IN,
  output reg EMCY_VALID_OUT,
  output reg [31:0] EMCY_DATA_OUT,
  input wire [7:0] BLANK_MS_IN,
  input wire [7:0] CH_TARGET_IN,
  input wire [7:0] CH_ACTUAL_IN,
  output reg [7:0] CH_FAULT_OUT,
  input wire SENS_SUPPLY_FAULT_IN,
  input wire ACT_SUPPLY_PRESENT_IN,
  input wire ACT_SUPPLY_FAULT_IN,
  input wire ACT_DIAG_ENABLE_IN,
  input wire INTERNAL_ERROR_IN,
  input wire FORCED_OUTPUT_IN,
  input wire [7:0] PORT_SUPPLY_SHORT_IN,
  input wire [7:0] DATA_LINE_SHORT_IN,
  input wire [7:0] AUX_INPUT_SHORT_IN,
  input wire [7:0] EXTRA_SUPPLY_SHORT_IN,
  output reg ACT_SUPPLY_MSG_OUT,
  input wire [23:0] PORT_STATE_IN,
  input wire [7:0] PORT_TELEGRAM_LOST_IN,
  input wire [7:0] PORT_COMM_FAULT_IN,
  output reg [7:0] PORT_ERROR_MSG_OUT
);

  reg [31:0] buf_mem [0:`DHQ_DEPTH-1];
  reg [7:0] newest_ff;
  reg [7:0] ack_ff;
  reg [6:0] count_ff;
  reg [6:0] acked_ff;
  reg read_ff;
  reg [15:0] flags_ff;
  wire [7:0] lost_cnt [0:`DHQ_NCH-1];
  wire [7:0] nxt_fault;
  reg [7:0] ch_sync1_ff, ch_sync2_ff, ch_sync3_ff;
  reg [7:0] on_sync1_ff, on_sync2_ff, on_sync3_ff;
  reg [7:0] on_prev_ff;
  reg [7:0] lost_s1_ff, lost_s2_ff, lost_s3_ff;
  reg [7:0] comm_s1_ff, comm_s2_ff, comm_s3_ff;
  reg [7:0] comm_prev_ff;
  reg [1:0] act_s_ff [0:2];

  wire ack_mode = flags_ff[`DHQ_FLG_ACKMODE];
  wire [5:0] newest_slot = newest_ff[5:0] - 6'd6;
  wire buf_full = (count_ff == 7'd64);

  // Age of the message held in a sub-index, 0 = newest
  function [6:0] age_of;
    input [7:0] si;
    input [7:0] newest;
    reg [5:0] d;
    begin
      d = newest[5:0] - si[5:0];
      age_of = {1'b0, d};
    end
  endfunction

  function [31:0] subreg;
    input [7:0] v;
    begin
      subreg = {24'h0000_00, v};
    end
  endfunction

  // Message filtering by severity
  reg store_ok;
  always @* begin
    case (MSG_SEV_IN)
      `DHQ_SEV_INFO: store_ok = !flags_ff[`DHQ_FLG_NOINFO];
      `DHQ_SEV_WARN: store_ok = !flags_ff[`DHQ_FLG_NOWARN];
      `DHQ_SEV_ERR: store_ok = !flags_ff[`DHQ_FLG_NOERR];
      default: store_ok = 1'b1;
    endcase
  end

  wire unacked_cnt_full = (count_ff - acked_ff) == 7'd64;
  wire push = MSG_VALID_IN && store_ok && !(ack_mode && buf_full && unacked_cnt_full);
  wire discard = MSG_VALID_IN && store_ok && ack_mode && buf_full && unacked_cnt_full;
  wire ack_wr = OBJ_WR_IN && OBJ_INDEX_IN == `DHQ_IDX_HIST && OBJ_SUB_IN == `DHQ_SI_ACK;
  wire [7:0] ack_val = OBJ_WDATA_IN[7:0];
  wire ack_in_range = ack_val >= `DHQ_SI_FIRST && ack_val <= `DHQ_SI_LAST;
  wire ack_has_msg = count_ff != 7'd0 && age_of(ack_val, newest_ff) < count_ff;
  wire ack_good = ack_in_range && ack_has_msg;

  wire ack_takes = ack_wr && (ack_val == 8'h00 || ack_good);
  always @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      newest_ff <= 8'h00;
      ack_ff <= 8'h00;
      count_ff <= 7'd0;
      acked_ff <= 7'd0;
      read_ff <= 1'b1;
      flags_ff <= `DHQ_FLG_RST;
      EMCY_VALID_OUT <= 1'b0;
      EMCY_DATA_OUT <= 32'h0000_0000;
    end else begin
      EMCY_VALID_OUT <= push && flags_ff[`DHQ_FLG_EMCY];
      if (push)
        EMCY_DATA_OUT <= MSG_DATA_IN;
      if (OBJ_WR_IN && OBJ_INDEX_IN == `DHQ_IDX_HIST && OBJ_SUB_IN == `DHQ_SI_FLAGS)
        flags_ff <= (OBJ_WDATA_IN[15:0] & `DHQ_FLG_WMASK) |
                    (flags_ff & ~`DHQ_FLG_WMASK & 16'h0020);
      if (OBJ_RD_IN && OBJ_INDEX_IN == `DHQ_IDX_HIST && OBJ_SUB_IN == `DHQ_SI_NEWEST)
        read_ff <= 1'b1;
      if (ack_wr && ack_val == 8'h00) begin
        if (!ack_mode) begin
          newest_ff <= 8'h00;
          ack_ff <= 8'h00;
          count_ff <= 7'd0;
          acked_ff <= 7'd0;
          read_ff <= 1'b1;
          flags_ff[`DHQ_FLG_OVR] <= 1'b0;
        end else begin
          count_ff <= count_ff - acked_ff;
          acked_ff <= 7'd0;
          ack_ff <= 8'h00;
        end
      end else if (ack_wr && ack_good) begin
        ack_ff <= ack_val;
        acked_ff <= count_ff - age_of(ack_val, newest_ff);
      end else if (push) begin
        newest_ff <= (newest_ff == `DHQ_SI_LAST || newest_ff == 8'h00) ?
                     `DHQ_SI_FIRST : newest_ff + 8'd1;
        read_ff <= 1'b0;
        if (!buf_full)
          count_ff <= count_ff + 7'd1;
        else if (acked_ff != 7'd0)
          acked_ff <= acked_ff - 7'd1;
        else if (!ack_mode) begin
          ack_ff <= 8'h00;
          flags_ff[`DHQ_FLG_OVR] <= 1'b1;
        end
        if (buf_full && acked_ff == 7'd1)
          ack_ff <= 8'h00;
      end
      if (discard)
        flags_ff[`DHQ_FLG_OVR] <= 1'b1;
    end
  end

  wire [5:0] wr_slot = (newest_ff == `DHQ_SI_LAST || newest_ff == 8'h00) ?
                       6'd0 : newest_ff[5:0] - 6'd5;
  always @(posedge SYS_CLK_IN) begin
    if (push && !ack_takes)
      buf_mem[wr_slot] <= MSG_DATA_IN;
  end

  // New message flag depends on mode
  wire new_avail = ack_mode ? (newest_ff != ack_ff && count_ff != acked_ff) :
                   (!read_ff && count_ff != 7'd0);

  wire [7:0] diag_bits = {3'b000, FORCED_OUTPUT_IN, INTERNAL_ERROR_IN,
                          ACT_SUPPLY_FAULT_IN, ACT_SUPPLY_PRESENT_IN, SENS_SUPPLY_FAULT_IN};
  wire [2:0] port_sel = OBJ_INDEX_IN[6:4];

  // Object read and write answers
  always @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      OBJ_RDATA_OUT <= 32'h0000_0000;
      OBJ_DONE_OUT <= 1'b0;
      OBJ_ABORT_OUT <= 1'b0;
      OBJ_ABORT_CODE_OUT <= 32'h0000_0000;
    end else begin
      OBJ_DONE_OUT <= OBJ_RD_IN || OBJ_WR_IN;
      OBJ_ABORT_OUT <= 1'b0;
      OBJ_ABORT_CODE_OUT <= 32'h0000_0000;
      OBJ_RDATA_OUT <= 32'h0000_0000;
      if (ack_wr && ack_val != 8'h00) begin
        if (ack_val <= `DHQ_SI_LOW) begin
          OBJ_ABORT_OUT <= 1'b1;
          OBJ_ABORT_CODE_OUT <= `DHQ_ABORT_LOW;
        end else if (ack_val > `DHQ_SI_LAST) begin
          OBJ_ABORT_OUT <= 1'b1;
          OBJ_ABORT_CODE_OUT <= `DHQ_ABORT_HIGH;
        end else if (!ack_has_msg) begin
          OBJ_ABORT_OUT <= 1'b1;
          OBJ_ABORT_CODE_OUT <= `DHQ_ABORT_NOMSG;
        end
      end else if (OBJ_RD_IN) begin
        if (OBJ_INDEX_IN == `DHQ_IDX_HIST) begin
          if (OBJ_SUB_IN == `DHQ_SI_CAP)
            OBJ_RDATA_OUT <= subreg(`DHQ_CAP_RST);
          else if (OBJ_SUB_IN == `DHQ_SI_NEWEST)
            OBJ_RDATA_OUT <= subreg(newest_ff);
          else if (OBJ_SUB_IN == `DHQ_SI_ACK)
            OBJ_RDATA_OUT <= subreg(ack_ff);
          else if (OBJ_SUB_IN == `DHQ_SI_NEWAV)
            OBJ_RDATA_OUT <= {31'h0000_0000, new_avail};
          else if (OBJ_SUB_IN == `DHQ_SI_FLAGS)
            OBJ_RDATA_OUT <= {16'h0000, flags_ff};
          else if (OBJ_SUB_IN >= `DHQ_SI_FIRST && OBJ_SUB_IN <= `DHQ_SI_LAST) begin
            if (count_ff != 7'd0 && age_of(OBJ_SUB_IN, newest_ff) < count_ff)
              OBJ_RDATA_OUT <= buf_mem[OBJ_SUB_IN[5:0] - 6'd6];
            else begin
              OBJ_ABORT_OUT <= 1'b1;
              OBJ_ABORT_CODE_OUT <= `DHQ_ABORT_NOMSG;
            end
          end else begin
            OBJ_ABORT_OUT <= 1'b1;
            OBJ_ABORT_CODE_OUT <= `DHQ_ABORT_NOOBJ;
          end
        end else if (OBJ_INDEX_IN == `DHQ_IDX_DIAG) begin
          case (OBJ_SUB_IN)
            8'h01: OBJ_RDATA_OUT <= {31'h0000_0000, diag_bits[0]};
            8'h02: OBJ_RDATA_OUT <= {31'h0000_0000, diag_bits[1]};
            8'h03: OBJ_RDATA_OUT <= {31'h0000_0000, diag_bits[2]};
            8'h04: OBJ_RDATA_OUT <= {31'h0000_0000, diag_bits[3]};
            8'h05: OBJ_RDATA_OUT <= {31'h0000_0000, diag_bits[4]};
            8'h06: OBJ_RDATA_OUT <= subreg(PORT_SUPPLY_SHORT_IN);
            8'h07: OBJ_RDATA_OUT <= subreg(DATA_LINE_SHORT_IN);
            8'h08: OBJ_RDATA_OUT <= subreg(AUX_INPUT_SHORT_IN);
            8'h09: OBJ_RDATA_OUT <= subreg(EXTRA_SUPPLY_SHORT_IN);
            default: begin
              OBJ_ABORT_OUT <= 1'b1;
              OBJ_ABORT_CODE_OUT <= `DHQ_ABORT_NOOBJ;
            end
          endcase
        end else if ((OBJ_INDEX_IN & 16'hFF8F) == `DHQ_IDX_PORT) begin
          if (OBJ_SUB_IN == 8'h01)
            OBJ_RDATA_OUT <= subreg(port_state(PORT_STATE_IN[port_sel*3 +: 3]));
          else if (OBJ_SUB_IN == 8'h02)
            OBJ_RDATA_OUT <= subreg(lost_cnt[port_sel]);
          else begin
            OBJ_ABORT_OUT <= 1'b1;
            OBJ_ABORT_CODE_OUT <= `DHQ_ABORT_NOOBJ;
          end
        end else begin
          OBJ_ABORT_OUT <= 1'b1;
          OBJ_ABORT_CODE_OUT <= `DHQ_ABORT_NOOBJ;
        end
      end else if (OBJ_WR_IN && !(OBJ_INDEX_IN == `DHQ_IDX_HIST &&
               (OBJ_SUB_IN == `DHQ_SI_ACK || OBJ_SUB_IN == `DHQ_SI_FLAGS))) begin
        OBJ_ABORT_OUT <= 1'b1;
        OBJ_ABORT_CODE_OUT <= `DHQ_ABORT_NOOBJ;
      end
    end
  end

  // Port state code 0..5 maps to the link state byte
  function [7:0] port_state;
    input [2:0] code;
    begin
      case (code)
        3'd1: port_state = `DHQ_LS_DI;
        3'd2: port_state = `DHQ_LS_DO;
        3'd3: port_state = `DHQ_LS_ESTAB;
        3'd4: port_state = `DHQ_LS_OPERATE;
        3'd5: port_state = `DHQ_LS_STOP;
        default: port_state = `DHQ_LS_INACTIVE;
      endcase
    end
  endfunction

  // Pin synchronisers, three stages
  always @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ch_sync1_ff <= 8'h00; ch_sync2_ff <= 8'h00; ch_sync3_ff <= 8'h00;
      on_sync1_ff <= 8'h00; on_sync2_ff <= 8'h00; on_sync3_ff <= 8'h00;
      lost_s1_ff <= 8'h00; lost_s2_ff <= 8'h00; lost_s3_ff <= 8'h00;
      comm_s1_ff <= 8'h00; comm_s2_ff <= 8'h00; comm_s3_ff <= 8'h00;
      comm_prev_ff <= 8'h00;
      on_prev_ff <= 8'h00;
      ACT_SUPPLY_MSG_OUT <= 1'b0;
      PORT_ERROR_MSG_OUT <= 8'h00;
      CH_FAULT_OUT <= 8'h00;
      act_s_ff[0] <= 2'b00; act_s_ff[1] <= 2'b00; act_s_ff[2] <= 2'b00;
    end else begin
      ch_sync1_ff <= CH_ACTUAL_IN ^ CH_TARGET_IN;
      ch_sync2_ff <= ch_sync1_ff;
      ch_sync3_ff <= ch_sync2_ff;
      on_sync1_ff <= CH_TARGET_IN;
      on_sync2_ff <= on_sync1_ff;
      on_sync3_ff <= on_sync2_ff;
      lost_s1_ff <= PORT_TELEGRAM_LOST_IN;
      lost_s2_ff <= lost_s1_ff;
      lost_s3_ff <= lost_s2_ff;
      comm_s1_ff <= PORT_COMM_FAULT_IN;
      comm_s2_ff <= comm_s1_ff;
      comm_s3_ff <= comm_s2_ff;
      act_s_ff[0] <= {ACT_DIAG_ENABLE_IN, ACT_SUPPLY_FAULT_IN};
      act_s_ff[1] <= act_s_ff[0];
      act_s_ff[2] <= act_s_ff[1];
      if (act_s_ff[1] == act_s_ff[2])
        ACT_SUPPLY_MSG_OUT <= act_s_ff[2][1] & act_s_ff[2][0];
      if (comm_s2_ff == comm_s3_ff) begin
        comm_prev_ff <= comm_s3_ff;
        PORT_ERROR_MSG_OUT <= comm_s3_ff & ~comm_prev_ff;
      end else
        PORT_ERROR_MSG_OUT <= 8'h00;
      if (on_sync2_ff == on_sync3_ff)
        on_prev_ff <= on_sync3_ff;
      CH_FAULT_OUT <= nxt_fault;
    end
  end

  // Per channel blanking and filter timers
  genvar g;
  generate
    for (g = 0; g < `DHQ_NCH; g = g + 1) begin : g_ch
      reg [15:0] ms_div_ff;
      reg [7:0] blank_ms_ff;
      reg [17:0] filt_ff;
      reg [7:0] lost_ff;
      wire on_stable = on_sync2_ff[g] == on_sync3_ff[g];
      wire rise = on_stable && on_sync3_ff[g] && !on_prev_ff[g];
      wire bad = ch_sync2_ff[g] == ch_sync3_ff[g] && ch_sync3_ff[g] && on_sync3_ff[g];
      assign lost_cnt[g] = lost_ff;
      assign nxt_fault[g] = bad && blank_ms_ff == 8'h00 && !rise &&
                            filt_ff == `DHQ_FILT_CYCLES;
      always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          ms_div_ff <= 16'h0000;
          blank_ms_ff <= 8'h00;
          filt_ff <= 18'h0_0000;
          lost_ff <= 8'h00;
        end else begin
          if (rise) begin
            blank_ms_ff <= BLANK_MS_IN;
            ms_div_ff <= 16'h0000;
          end else if (blank_ms_ff != 8'h00) begin
            if (ms_div_ff == `DHQ_MS_CYCLES - 16'h0001) begin
              ms_div_ff <= 16'h0000;
              blank_ms_ff <= blank_ms_ff - 8'h01;
            end else
              ms_div_ff <= ms_div_ff + 16'h0001;
          end
          if (!bad || rise)
            filt_ff <= 18'h0_0000;
          else if (filt_ff != `DHQ_FILT_CYCLES)
            filt_ff <= filt_ff + 18'h0_0001;
          if (lost_s2_ff[g] == lost_s3_ff[g] && lost_s3_ff[g] &&
              !comm_prev_ff[g] && lost_ff != 8'hFF)
            lost_ff <= lost_ff + 8'h01;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== testbench/dhq_top_asserts.sv
// Assertion checker for dhq_top, bound to its ports.
// Assumes one-cycle object strobes answered one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "dhq_map.vh"
module dhq_asserts (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic OBJ_WR_IN,
  input wire logic OBJ_RD_IN,
  input wire logic [15:0] OBJ_INDEX_IN,
  input wire logic [7:0] OBJ_SUB_IN,
  input wire logic [31:0] OBJ_WDATA_IN,
  input wire logic [31:0] OBJ_RDATA_OUT,
  input wire logic OBJ_DONE_OUT,
  input wire logic OBJ_ABORT_OUT,
  input wire logic [31:0] OBJ_ABORT_CODE_OUT,
  input wire logic ACT_DIAG_ENABLE_IN,
  input wire logic ACT_SUPPLY_MSG_OUT
);
  wire hist = OBJ_INDEX_IN == `DHQ_IDX_HIST;
  wire rdh = OBJ_RD_IN && hist;
  wire ackw = OBJ_WR_IN && hist && OBJ_SUB_IN == `DHQ_SI_ACK;
  wire [31:0] wd = OBJ_WDATA_IN;
  wire [31:0] rv = OBJ_RDATA_OUT;
  wire [31:0] cd = OBJ_ABORT_CODE_OUT;
  wire ab = OBJ_ABORT_OUT;
  wire lsr = OBJ_RD_IN && OBJ_INDEX_IN[15:8] == 8'hA0 && !OBJ_INDEX_IN[7] &&
             OBJ_INDEX_IN[3:0] == 4'h0;
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  a_ack_too_low: assert property (ackw && wd inside {[1:5]} |=> ab && cd == `DHQ_ABORT_LOW)
    else $error("ack write 1..5 not refused");
  a_ack_too_high: assert property (ackw && wd > 69 && wd < 256 |=> ab && cd == `DHQ_ABORT_HIGH)
    else $error("ack write above 69 not refused");
  a_ack_zero_ok: assert property (ackw && wd == 0 |=> OBJ_DONE_OUT && !ab)
    else $error("ack write 0 refused");
  a_newest_range: assert property (rdh && OBJ_SUB_IN == `DHQ_SI_NEWEST
    |=> rv == 0 || (rv >= 6 && rv <= 69)) else $error("newest pointer out of range");
  a_cap_value: assert property (rdh && OBJ_SUB_IN == `DHQ_SI_CAP |=> rv == 32'h0000_0040)
    else $error("capacity wrong");
  a_flags_reserved: assert property (rdh && OBJ_SUB_IN == `DHQ_SI_FLAGS |=> rv[31:6] == 0)
    else $error("reserved flag bits set");
  a_newav_bit: assert property (rdh && OBJ_SUB_IN == `DHQ_SI_NEWAV |=> rv[31:1] == 0)
    else $error("new flag not boolean");
  a_link_code: assert property (lsr && OBJ_SUB_IN == 8'h01 |=> !ab && rv[31:8] == 0
    && rv[7:0] inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09}) else $error("bad link code");
  a_supply_gate: assert property (!ACT_DIAG_ENABLE_IN [*5] |-> !ACT_SUPPLY_MSG_OUT)
    else $error("supply message while disabled");
  c_abort: cover property (OBJ_DONE_OUT && ab);
  c_ack_write: cover property (ackw ##1 OBJ_DONE_OUT && !ab);
  c_supply_msg: cover property (ACT_SUPPLY_MSG_OUT);
endmodule
bind dhq_top dhq_asserts dhq_asserts_i (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
  .OBJ_WR_IN(OBJ_WR_IN), .OBJ_RD_IN(OBJ_RD_IN), .OBJ_INDEX_IN(OBJ_INDEX_IN),
  .OBJ_SUB_IN(OBJ_SUB_IN), .OBJ_WDATA_IN(OBJ_WDATA_IN), .OBJ_RDATA_OUT(OBJ_RDATA_OUT),
  .OBJ_DONE_OUT(OBJ_DONE_OUT), .OBJ_ABORT_OUT(OBJ_ABORT_OUT),
  .OBJ_ABORT_CODE_OUT(OBJ_ABORT_CODE_OUT), .ACT_DIAG_ENABLE_IN(ACT_DIAG_ENABLE_IN),
  .ACT_SUPPLY_MSG_OUT(ACT_SUPPLY_MSG_OUT));
`default_nettype wire

// ===== testbench/dhq_master.sv
// Fieldbus master model issuing object reads and writes.
// Assumes a one-cycle strobe answered by done one cycle later.
`timescale 1ns/1ps
`default_nettype none
module dhq_master (
  input wire logic clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] index_out,
  output logic [7:0] sub_out,
  output logic [31:0] wdata_out,
  input wire logic [31:0] rdata_in,
  input wire logic done_in,
  input wire logic abort_in,
  input wire logic [31:0] code_in
);
  int gap = 0;
  initial begin
    {wr_out, rd_out} = 2'b00;
    index_out = 16'h0000;
    sub_out = 8'h00;
    wdata_out = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [15:0] x, input logic [7:0] s,
      input logic [31:0] d, output logic [31:0] r, output logic b, output logic [31:0] c,
      output logic ok);
    repeat (gap + 1) @(posedge clk_in);
    #1;
    wr_out = w;
    rd_out = !w;
    index_out = x;
    sub_out = s;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    {wr_out, rd_out} = 2'b00;
    // Released fields show inverted values so stale data cannot pass
    index_out = ~x;
    sub_out = ~s;
    wdata_out = ~d;
    ok = done_in;
    r = rdata_in;
    b = abort_in;
    c = code_in;
  endtask
endmodule
`default_nettype wire

// ===== testbench/dhq_top_bench.sv
// Self-checking bench for dhq_top driven through dhq_master.
// Assumes a 40 MHz clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "dhq_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end
module dhq_top_bench;
  logic clk, rst, wr, rd, done, ab, mv, ev, sf, ap, af, ae, ie, fo, asm;
  logic [1:0] sev, fseen;
  logic [7:0] sub, blank, tgt, act, fault, ps, dl, ax, ex, lost, cf, perr, pseen;
  logic [15:0] idx;
  logic [23:0] pst;
  logic [31:0] wd, rdat, code, md, ed, elast;
  int failures = 0;
  int cmp_count = 0;
  int ecount = 0;
  int i, k;
  localparam logic [7:0] si_cap = `DHQ_SI_CAP;
  localparam logic [7:0] si_nw = `DHQ_SI_NEWEST;
  localparam logic [7:0] si_ack = `DHQ_SI_ACK;
  localparam logic [7:0] si_av = `DHQ_SI_NEWAV;
  localparam logic [7:0] si_fl = `DHQ_SI_FLAGS;
  logic [7:0] ls [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09};
  logic [7:0] dexp [9] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h01, 8'h5A, 8'hA5, 8'h3C, 8'hC3};
  dhq_top dhq_top_i (.SYS_CLK_IN(clk), .RST_IN(rst), .OBJ_WR_IN(wr), .OBJ_RD_IN(rd),
    .OBJ_INDEX_IN(idx), .OBJ_SUB_IN(sub), .OBJ_WDATA_IN(wd), .OBJ_RDATA_OUT(rdat),
    .OBJ_DONE_OUT(done), .OBJ_ABORT_OUT(ab), .OBJ_ABORT_CODE_OUT(code), .MSG_VALID_IN(mv),
    .MSG_SEV_IN(sev), .MSG_DATA_IN(md), .EMCY_VALID_OUT(ev), .EMCY_DATA_OUT(ed),
    .BLANK_MS_IN(blank), .CH_TARGET_IN(tgt), .CH_ACTUAL_IN(act), .CH_FAULT_OUT(fault),
    .SENS_SUPPLY_FAULT_IN(sf), .ACT_SUPPLY_PRESENT_IN(ap), .ACT_SUPPLY_FAULT_IN(af),
    .ACT_DIAG_ENABLE_IN(ae), .INTERNAL_ERROR_IN(ie), .FORCED_OUTPUT_IN(fo),
    .PORT_SUPPLY_SHORT_IN(ps), .DATA_LINE_SHORT_IN(dl), .AUX_INPUT_SHORT_IN(ax),
    .EXTRA_SUPPLY_SHORT_IN(ex), .ACT_SUPPLY_MSG_OUT(asm), .PORT_STATE_IN(pst),
    .PORT_TELEGRAM_LOST_IN(lost), .PORT_COMM_FAULT_IN(cf), .PORT_ERROR_MSG_OUT(perr));
  dhq_master dhq_master_i (.clk_in(clk), .wr_out(wr), .rd_out(rd), .index_out(idx),
    .sub_out(sub), .wdata_out(wd), .rdata_in(rdat), .done_in(done), .abort_in(ab),
    .code_in(code));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] s, input logic [31:0] d, e,
      input logic a, input logic [15:0] x = `DHQ_IDX_HIST);
    logic [31:0] r, c;
    logic b, ok;
    dhq_master_i.xfer(w, x, s, d, r, b, c, ok);
    `CHK(ok, 1'b1)
    `CHK(b, a)
    if (a) `CHK(c, e) else if (!w) `CHK(r, e)
  endtask
  task automatic rh(input logic [7:0] s, input logic [31:0] e);
    acc(1'b0, s, 32'h0000_0000, e, 1'b0);
  endtask
  task automatic wh(input logic [7:0] s, input logic [31:0] d);
    acc(1'b1, s, d, 32'h0000_0000, 1'b0);
  endtask
  task automatic rej(input logic [7:0] d, input logic [31:0] e);
    acc(1'b1, si_ack, {24'h00_0000, d}, e, 1'b1);
  endtask
  task automatic msg(input logic [1:0] s, input logic [31:0] d);
    @(posedge clk);
    #1 {mv, sev, md} = {1'b1, s, d};
    @(posedge clk);
    #1 {mv, md} = {1'b0, ~d};
  endtask
  always @(posedge clk) begin
    if (ev === 1'b1) begin
      ecount++;
      elast = ed;
    end
    pseen = pseen | perr;
    fseen = fseen | fault[1:0];
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin
    {rst, sf, af, fo, mv, ap, ae, ie} = 8'hF0;
    {tgt, act, lost, cf} = 32'h0000_0000;
    {ps, dl, ax, ex} = 32'h5AA5_3CC3;
    {sev, fseen, md, pst, pseen} = 68'h0;
    blank = 8'h01;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    rh(si_cap, 8'h40);
    rh(si_nw, 8'h00);
    rh(si_ack, 8'h00);
    rh(si_av, 8'h00);
    rh(si_fl, 8'h00);
    for (i = 0; i < 9; i++) acc(1'b0, 8'(i + 1), 32'h0, {24'h0, dexp[i]}, 1'b0, `DHQ_IDX_DIAG);
    acc(1'b1, si_cap, 8'h05, `DHQ_ABORT_NOOBJ, 1'b1);
    acc(1'b0, si_cap, 8'h00, `DHQ_ABORT_NOOBJ, 1'b1, 16'h3000);
    $display("test reset_values done");
    for (i = 0; i < 3; i++) msg(`DHQ_SEV_ERR, 32'h0E00_0000 + i);
    rh(si_av, 8'h01);
    rh(si_nw, 8'h08);
    rh(si_av, 8'h00);
    rh(8'h07, 32'h0E00_0001);
    rej(8'h03, `DHQ_ABORT_LOW);
    rej(8'h46, `DHQ_ABORT_HIGH);
    rej(8'hFF, `DHQ_ABORT_HIGH);
    rej(8'h09, `DHQ_ABORT_NOMSG);
    wh(si_ack, 8'h07);
    rh(si_ack, 8'h07);
    $display("test ack_pointer done");
    for (i = 0; i < 3; i++) begin
      wh(si_fl, 8'h02 << i);
      msg(2'(i), 32'h0000_0000);
      rh(si_nw, 8'h08 + i);
      msg(2'((i + 1) % 3), 32'h0000_0000);
      rh(si_nw, 8'h09 + i);
    end
    wh(si_fl, 32'h0000_FFE0);
    rh(si_fl, 8'h00);
    wh(si_fl, 8'h01);
    msg(`DHQ_SEV_WARN, 32'hCAFE_0001);
    for (k = 0; k < 20 && ecount == 0; k++) @(posedge clk);
    `CHK(ecount, 1)
    `CHK(elast, 32'hCAFE_0001)
    wh(si_fl, 8'h00);
    $display("test filters done");
    wh(si_ack, 8'h00);
    rh(si_nw, 8'h00);
    rh(si_av, 8'h00);
    for (i = 0; i < 64; i++) msg(`DHQ_SEV_INFO, 32'hD000_0000 + i);
    rh(si_nw, 8'h45);
    wh(si_ack, 8'h06);
    msg(`DHQ_SEV_INFO, 32'hD000_0040);
    msg(`DHQ_SEV_INFO, 32'hD000_0041);
    rh(si_nw, 8'h07);
    rh(8'h07, 32'hD000_0041);
    rh(si_ack, 8'h00);
    rh(si_fl, 8'h20);
    wh(si_ack, 8'h00);
    rh(si_fl, 8'h00);
    rh(si_nw, 8'h00);
    rej(8'h06, `DHQ_ABORT_NOMSG);
    $display("test overwrite done");
    dhq_master_i.gap = 3;
    wh(si_fl, 8'h10);
    for (i = 0; i < 65; i++) msg(`DHQ_SEV_WARN, 32'hB000_0000 + i);
    rh(si_nw, 8'h45);
    rh(8'h06, 32'hB000_0000);
    rh(si_fl, 8'h30);
    rh(si_av, 8'h01);
    wh(si_ack, 8'h45);
    rh(si_av, 8'h00);
    wh(si_ack, 8'h00);
    rh(si_ack, 8'h00);
    rej(8'h06, `DHQ_ABORT_NOMSG);
    wh(si_fl, 8'h00);
    dhq_master_i.gap = 0;
    $display("test acknowledge done");
    for (i = 0; i < 8; i++) pst[3 * i +: 3] = 3'(i % 6);
    lost = 8'h03;
    repeat (3) @(posedge clk);
    #1 lost = 8'h02;
    repeat (297) @(posedge clk);
    #1 lost = 8'h00;
    repeat (4) @(posedge clk);
    for (i = 0; i < 8; i++) acc(1'b0, 8'h01, 0, ls[i % 6], 1'b0, 16'hA000 + 16'(i * 16));
    // Agree filter drops the last sampled cycle of a three-cycle pulse
    acc(1'b0, 8'h02, 32'h0, 8'h02, 1'b0, 16'hA000);
    acc(1'b0, 8'h02, 32'h0, 8'hFF, 1'b0, 16'hA010);
    acc(1'b0, 8'h02, 32'h0, 8'h00, 1'b0, 16'hA020);
    $display("test ports done");
    cf = 8'h10;
    repeat (8) @(posedge clk);
    #1;
    `CHK(asm, 1'b0)
    `CHK(pseen, 8'h10)
    ae = 1'b1;
    for (k = 0; k < 20 && asm !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK(asm, 1'b1)
    {tgt, act, fseen} = 18'h0_0C00;
    repeat (36000) @(posedge clk);
    `CHK(fseen, 2'b00)
    $display("test faults done");
    complete_run();
  end
endmodule
`default_nettype wire
